// File: core/pam_frame_mem.sv
// byte memory holding one received request frame
`timescale 1ns/10ps
`default_nettype none
module pam_frame_mem (
  input wire logic clock,
  input wire logic ce,
  pam_mem_if.mem port
);
  logic [7:0] store [pam_pkg::MEM_DEPTH];

  always_ff @(posedge clock) begin
    if (ce && port.wrEn) begin
      store[port.wrAddr] <= port.wrData;
    end
  end

  always_ff @(posedge clock) begin
    if (ce) begin
      port.rdData <= store[port.rdAddr];
    end
  end
endmodule // pam_frame_mem
`default_nettype wire

// File: core/pam_mem_if.sv
// handler to frame memory carrier
`timescale 1ns/10ps
`default_nettype none
interface pam_mem_if;
  logic wrEn;
  logic [pam_pkg::MEM_AW-1:0] wrAddr;
  logic [7:0] wrData;
  logic [pam_pkg::MEM_AW-1:0] rdAddr;
  logic [7:0] rdData;
  modport ctrl (output wrEn, wrAddr, wrData, rdAddr, input rdData);
  modport mem (input wrEn, wrAddr, wrData, rdAddr, output rdData);
endinterface
`default_nettype wire

// File: core/pam_msg_handler.sv
// power management and audio control message handler
// Contract
// (RULE_01) standby request: length 4, id 0x0064
// (RULE_02) standby response: id 0x0065, result
// (RULE_03) send good response before entering standby
// (RULE_04) denied standby: error code, stay normal
// (RULE_05) after wake send exit indication 0x0066
// (RULE_06) config request: 12 bytes, gain, rate
// (RULE_07) gain code 0x01..0x43 maps -48..+18 dB
// (RULE_08) gain above 0x43 mutes, locks volume
// (RULE_09) volume request adds signed offset to gain
// (RULE_10) out of range volume mutes and locks
// (RULE_11) host tracks volume, no readback exists
// (RULE_12) volume response id 0x0011 with result
// (RULE_13) config response id 0x0009 with result
// (RULE_14) mute request: 0 off, 1 on
// (RULE_15) stop requests release digital mute
// (RULE_16) no volume request during transfer stages
// (RULE_17) no mute request during transfer stages
// (RULE_18) change volume between decode and ready
// (RULE_19) pause indication on pause, end, underrun
// (RULE_20) pause waits for stop response
// (RULE_21) host configures audio before output starts
// (RULE_22) host drives exit pin for standby
// (RULE_23) wake within 120 ms, raise message ready
// (RULE_24) pause indication: length 4, id 0x007C
// (RULE_25) one matching response per accepted request
`timescale 1ns/10ps
`default_nettype none
module pam_msg_handler #(
  parameter int WAKE_CYCLES = pam_pkg::WAKE_CYCLES_DEF
) (
  input wire logic clock,
  input wire logic nrst,
  input wire logic ce,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic rxValid,
  input wire logic [7:0] rxData,
  output logic rxReady,
  output logic txValid,
  output logic [7:0] txData,
  input wire logic txReady,
  input wire logic standbyExitPin,
  output logic messageReadyPin,
  output logic standbyReq,
  input wire logic pauseCmdEvt,
  input wire logic playEndEvt,
  input wire logic underrunEvt,
  input wire logic decStopReq,
  input wire logic seqStopReq,
  input wire logic decStopRespSent,
  output logic [7:0] gainCode,
  output logic [7:0] sampleRate,
  output logic audioMute
);
  pam_pkg::pam_state_t state_reg;
  pam_mem_if memBus ();
  logic [1:0] pinSync_reg;
  logic pinHigh;
  logic [15:0] byteCnt_reg;
  logic [15:0] len_reg;
  logic [15:0] id_reg;
  logic [1:0] fetchCnt_reg;
  logic [7:0] b4_reg;
  logic [7:0] b5_reg;
  logic [7:0] b7_reg;
  logic [15:0] txLen_reg;
  logic [15:0] txId_reg;
  logic [15:0] txRes_reg;
  logic [15:0] txIdx_reg;
  logic [7:0] txData_reg;
  logic arm_reg;
  logic [23:0] wakeCnt_reg;
  logic msgReady_reg;
  logic standby_reg;
  logic exitPend_reg;
  logic pausePend_reg;
  logic stopPend_reg;
  logic [7:0] gain_reg;
  logic [7:0] rate_reg;
  logic lock_reg;
  logic muteOn_reg;
  logic muteOut_reg;
  logic permit_reg;
  logic permitNext;
  logic wrPend_reg;
  logic [7:0] addrQ_reg;
  logic [31:0] hrdata_reg;
  logic rxTake;
  logic rxLast;
  logic pauseGo;
  logic indStart;
  logic txDone;
  logic busRead;
  // decode results of one request
  logic rspValid;
  logic [15:0] rspId;
  logic [15:0] rspRes;
  logic gainWr;
  logic [7:0] gainNew;
  logic rateWr;
  logic lockSet;
  logic lockClr;
  logic muteWr;
  logic armNow;
  logic [16:0] volSum;

  function automatic logic [7:0] frameByte(input logic [15:0] idx, input logic [15:0] len,
                                           input logic [15:0] id, input logic [15:0] res);
    logic [7:0] b;
    b = 8'h00;
    case (idx[2:0])
      3'h0: b = len[7:0];
      3'h1: b = len[15:8];
      3'h2: b = id[7:0];
      3'h3: b = id[15:8];
      3'h4: b = res[7:0];
      3'h5: b = res[15:8];
      default: b = 8'h00;
    endcase
    return b;
  endfunction

  pam_frame_mem frameMem (
    .clock(clock),
    .ce(ce),
    .port(memBus.mem)
  );

  // pin is asynchronous
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      pinSync_reg <= 2'h0;
    end else if (ce) begin
      pinSync_reg <= {pinSync_reg[0], standbyExitPin};
    end
  end
  assign pinHigh = pinSync_reg[1];

  // receive path
  assign pauseGo = pausePend_reg && !stopPend_reg && !decStopReq; // RULE_20
  assign indStart = (byteCnt_reg == 16'h0000) && (exitPend_reg || pauseGo);
  assign rxReady = (state_reg == pam_pkg::ST_RX) && !indStart;
  assign rxTake = rxReady && rxValid;
  assign rxLast = (byteCnt_reg >= 16'h0003) && ((byteCnt_reg + 16'h0001) >= len_reg);
  assign memBus.wrEn = rxTake && (byteCnt_reg < 16'(pam_pkg::MEM_DEPTH));
  assign memBus.wrAddr = byteCnt_reg[pam_pkg::MEM_AW-1:0];
  assign memBus.wrData = rxData;
  assign memBus.rdAddr = (fetchCnt_reg == 2'h0) ? pam_pkg::POS_LO :
                         (fetchCnt_reg == 2'h1) ? pam_pkg::POS_HI : pam_pkg::POS_RATE;
  assign txValid = (state_reg == pam_pkg::ST_TX);
  assign txData = txData_reg;
  assign txDone = txValid && txReady && ((txIdx_reg + 16'h0001) >= txLen_reg);

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      byteCnt_reg <= 16'h0000;
      len_reg <= 16'h0000;
      id_reg <= 16'h0000;
    end else if (ce && rxTake) begin
      byteCnt_reg <= rxLast ? 16'h0000 : byteCnt_reg + 16'h0001;
      case (byteCnt_reg)
        16'h0000: len_reg[7:0] <= rxData;
        16'h0001: len_reg[15:8] <= rxData;
        16'h0002: id_reg[7:0] <= rxData;
        16'h0003: id_reg[15:8] <= rxData;
        default: ;
      endcase
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      fetchCnt_reg <= 2'h0;
      b4_reg <= 8'h00;
      b5_reg <= 8'h00;
      b7_reg <= 8'h00;
    end else if (ce) begin
      if (state_reg == pam_pkg::ST_FETCH) begin
        fetchCnt_reg <= fetchCnt_reg + 2'h1;
        case (fetchCnt_reg)
          2'h1: b4_reg <= memBus.rdData;
          2'h2: b5_reg <= memBus.rdData;
          2'h3: b7_reg <= memBus.rdData;
          default: ;
        endcase
      end else begin
        fetchCnt_reg <= 2'h0;
      end
    end
  end

  // unknown ids get no response
  always_comb begin
    rspValid = 1'b1;
    rspId = pam_pkg::ID_CFG_RSP;
    rspRes = pam_pkg::RES_OK;
    gainWr = 1'b0;
    gainNew = b5_reg;
    rateWr = 1'b0;
    lockSet = 1'b0;
    lockClr = 1'b0;
    muteWr = 1'b0;
    armNow = 1'b0;
    volSum = 17'({9'h000, gain_reg}) + {b5_reg[7], b5_reg, b4_reg}; // RULE_09
    case (id_reg)
      pam_pkg::ID_STBY_REQ: begin
        rspId = pam_pkg::ID_STBY_RSP; // RULE_02
        // pin must already be low
        if (len_reg == pam_pkg::LEN_SHORT && permit_reg && !pinHigh) begin // RULE_01
          armNow = 1'b1;
        end else begin
          rspRes = pam_pkg::ERR_STBY_DENIED; // RULE_04
        end
      end
      pam_pkg::ID_CFG_REQ: begin
        rspId = pam_pkg::ID_CFG_RSP; // RULE_13
        if (len_reg != pam_pkg::LEN_CONFIG || (b7_reg != pam_pkg::RATE_16K && b7_reg != pam_pkg::RATE_ANY)) begin
          rspRes = pam_pkg::ERR_BAD_CONTENT; // RULE_06
        end else begin
          gainWr = 1'b1;
          rateWr = 1'b1;
          if (b5_reg > pam_pkg::GAIN_MAX) begin
            lockSet = 1'b1; // RULE_08
            rspRes = pam_pkg::ERR_GAIN_RANGE;
          end else begin
            lockClr = 1'b1;
          end
        end
      end
      pam_pkg::ID_VOL_REQ: begin
        rspId = pam_pkg::ID_VOL_RSP; // RULE_12
        gainNew = volSum[7:0];
        if (len_reg != pam_pkg::LEN_RESULT) begin
          rspRes = pam_pkg::ERR_BAD_CONTENT;
        end else if (lock_reg) begin
          rspRes = pam_pkg::ERR_VOL_LOCKED; // RULE_08
        end else if (volSum[16] || volSum[15:0] > 16'(pam_pkg::GAIN_MAX)) begin
          lockSet = 1'b1; // RULE_10
          rspRes = pam_pkg::ERR_GAIN_RANGE;
        end else begin
          gainWr = 1'b1;
        end
      end
      pam_pkg::ID_MUTE_REQ: begin
        rspId = pam_pkg::ID_MUTE_RSP;
        if (len_reg == pam_pkg::LEN_RESULT &&
            ({b5_reg, b4_reg} == pam_pkg::MUTE_OFF || {b5_reg, b4_reg} == pam_pkg::MUTE_ON)) begin
          muteWr = 1'b1; // RULE_14
        end else begin
          rspRes = pam_pkg::ERR_BAD_CONTENT;
        end
      end
      default: rspValid = 1'b0;
    endcase
  end

  // main sequence
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      state_reg <= pam_pkg::ST_RX;
      arm_reg <= 1'b0;
      wakeCnt_reg <= 24'h00_0000;
    end else if (ce) begin
      case (state_reg)
        pam_pkg::ST_RX: begin
          if (indStart) begin
            state_reg <= pam_pkg::ST_TX;
          end else if (rxTake && rxLast) begin
            state_reg <= pam_pkg::ST_FETCH;
          end
        end
        pam_pkg::ST_FETCH: begin
          if (fetchCnt_reg == 2'h3) begin
            state_reg <= pam_pkg::ST_EXEC;
          end
        end
        pam_pkg::ST_EXEC: begin
          arm_reg <= armNow;
          state_reg <= rspValid ? pam_pkg::ST_TX : pam_pkg::ST_RX; // RULE_25
        end
        pam_pkg::ST_TX: begin
          if (txDone) begin
            arm_reg <= 1'b0;
            state_reg <= arm_reg ? pam_pkg::ST_ARM : pam_pkg::ST_RX; // RULE_03
          end
        end
        pam_pkg::ST_ARM: begin
          if (pinHigh) begin
            state_reg <= pam_pkg::ST_SLEEP; // RULE_22
          end
        end
        pam_pkg::ST_SLEEP: begin
          wakeCnt_reg <= 24'h00_0000;
          if (!pinHigh) begin
            state_reg <= pam_pkg::ST_WAKE;
          end
        end
        pam_pkg::ST_WAKE: begin
          wakeCnt_reg <= wakeCnt_reg + 24'h00_0001;
          if (wakeCnt_reg >= 24'(WAKE_CYCLES - 1)) begin
            state_reg <= pam_pkg::ST_RX; // RULE_23
          end
        end
        default: state_reg <= pam_pkg::ST_RX;
      endcase
    end
  end

  // transmit frame loading and stepping
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      txLen_reg <= pam_pkg::LEN_SHORT;
      txId_reg <= 16'h0000;
      txRes_reg <= pam_pkg::RES_OK;
      txIdx_reg <= 16'h0000;
      txData_reg <= 8'h00;
    end else if (ce) begin
      txIdx_reg <= 16'h0000;
      if (state_reg == pam_pkg::ST_RX && indStart) begin
        // exit indication ahead of a pending pause
        txLen_reg <= pam_pkg::LEN_SHORT;
        txId_reg <= exitPend_reg ? pam_pkg::ID_STBY_EXIT : pam_pkg::ID_PAUSE_IND; // RULE_05 RULE_24
        txData_reg <= frameByte(16'h0000, pam_pkg::LEN_SHORT, 16'h0000, 16'h0000);
      end else if (state_reg == pam_pkg::ST_EXEC) begin
        txLen_reg <= pam_pkg::LEN_RESULT;
        txId_reg <= rspId;
        txRes_reg <= rspRes;
        txData_reg <= frameByte(16'h0000, pam_pkg::LEN_RESULT, 16'h0000, 16'h0000);
      end else if (state_reg == pam_pkg::ST_TX) begin
        txIdx_reg <= txIdx_reg;
        if (txValid && txReady) begin
          txIdx_reg <= txIdx_reg + 16'h0001;
          txData_reg <= frameByte(txIdx_reg + 16'h0001, txLen_reg, txId_reg, txRes_reg);
        end
      end
    end
  end

  // standby and message ready pin
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      standby_reg <= 1'b0;
      msgReady_reg <= 1'b1;
      exitPend_reg <= 1'b0;
    end else if (ce) begin
      if (state_reg == pam_pkg::ST_ARM && pinHigh) begin
        standby_reg <= 1'b1;
        msgReady_reg <= 1'b0;
      end else if (state_reg == pam_pkg::ST_WAKE && wakeCnt_reg >= 24'(WAKE_CYCLES - 1)) begin
        standby_reg <= 1'b0;
        msgReady_reg <= 1'b1; // RULE_23
        exitPend_reg <= 1'b1; // RULE_05
      end else if (state_reg == pam_pkg::ST_RX && indStart && exitPend_reg) begin
        exitPend_reg <= 1'b0;
      end
    end
  end

  // stop ordering; set wins over clear
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      pausePend_reg <= 1'b0;
      stopPend_reg <= 1'b0;
    end else if (ce) begin
      if (pauseCmdEvt || playEndEvt || underrunEvt) begin
        pausePend_reg <= 1'b1; // RULE_19
      end else if (state_reg == pam_pkg::ST_RX && indStart && !exitPend_reg) begin
        pausePend_reg <= 1'b0;
      end
      if (decStopReq) begin
        stopPend_reg <= 1'b1; // RULE_20
      end else if (decStopRespSent) begin
        stopPend_reg <= 1'b0;
      end
    end
  end

  // gain code is the dB step index
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      gain_reg <= pam_pkg::GAIN_RESET;
      rate_reg <= pam_pkg::RATE_RESET;
      lock_reg <= 1'b0;
      muteOn_reg <= 1'b0;
      muteOut_reg <= 1'b0;
    end else if (ce) begin
      if (state_reg == pam_pkg::ST_EXEC) begin
        if (gainWr) begin
          gain_reg <= gainNew; // RULE_07
        end
        if (rateWr) begin
          rate_reg <= b7_reg;
        end
        if (lockSet) begin
          lock_reg <= 1'b1;
        end else if (lockClr) begin
          lock_reg <= 1'b0;
        end
      end
      if (decStopReq || seqStopReq) begin
        muteOn_reg <= 1'b0; // RULE_15
      end else if (state_reg == pam_pkg::ST_EXEC && muteWr) begin
        muteOn_reg <= b4_reg[0];
      end
      // locked or zero gain plays silence, not a stale level
      muteOut_reg <= muteOn_reg || lock_reg || gain_reg == 8'h00 || standby_reg; // RULE_08
    end
  end

  assign gainCode = gain_reg;
  assign sampleRate = rate_reg;
  assign audioMute = muteOut_reg;
  assign standbyReq = standby_reg;
  assign messageReadyPin = msgReady_reg;

  // bus slave, zero wait states
  assign busRead = hsel && htrans[1] && !hwrite && hready;
  assign permitNext = (wrPend_reg && addrQ_reg == pam_pkg::OFF_CTRL) ? hwdata[pam_pkg::CTRL_PERMIT_BIT] : permit_reg;

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      wrPend_reg <= 1'b0;
      addrQ_reg <= 8'h00;
      hrdata_reg <= 32'h0000_0000;
      permit_reg <= pam_pkg::CTRL_PERMIT_RESET;
    end else if (ce) begin
      permit_reg <= permitNext;
      if (hready) begin
        wrPend_reg <= hsel && htrans[1] && hwrite;
        addrQ_reg <= haddr[7:0];
      end
      hrdata_reg <= 32'h0000_0000;
      if (busRead && haddr[7:0] == pam_pkg::OFF_CTRL) begin
        hrdata_reg[pam_pkg::CTRL_PERMIT_BIT] <= permitNext;
      end else if (busRead && haddr[7:0] == pam_pkg::OFF_STATUS) begin
        // gain is deliberately not readable here
        hrdata_reg[pam_pkg::STAT_MUTE_BIT] <= muteOut_reg;
        hrdata_reg[pam_pkg::STAT_LOCK_BIT] <= lock_reg;
        hrdata_reg[pam_pkg::STAT_STBY_BIT] <= standby_reg;
        hrdata_reg[pam_pkg::STAT_PAUSE_BIT] <= pausePend_reg;
        hrdata_reg[pam_pkg::STAT_STOP_BIT] <= stopPend_reg;
      end
    end
  end

  assign hrdata = hrdata_reg;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
endmodule // pam_msg_handler
`default_nettype wire

// File: core/pam_pkg.sv
// constants for the power and audio message handler
package pam_pkg;
  // frame lengths and message identifiers
  localparam logic [15:0] LEN_SHORT = 16'h0004;
  localparam logic [15:0] LEN_RESULT = 16'h0006;
  localparam logic [15:0] LEN_CONFIG = 16'h000C;
  localparam logic [15:0] ID_STBY_REQ = 16'h0064;
  localparam logic [15:0] ID_STBY_RSP = 16'h0065;
  localparam logic [15:0] ID_STBY_EXIT = 16'h0066;
  localparam logic [15:0] ID_CFG_REQ = 16'h0008;
  localparam logic [15:0] ID_CFG_RSP = 16'h0009;
  localparam logic [15:0] ID_VOL_REQ = 16'h0010;
  localparam logic [15:0] ID_VOL_RSP = 16'h0011;
  localparam logic [15:0] ID_MUTE_REQ = 16'h000C;
  localparam logic [15:0] ID_MUTE_RSP = 16'h000D;
  localparam logic [15:0] ID_PAUSE_IND = 16'h007C;
  // result codes
  localparam logic [15:0] RES_OK = 16'h0000;
  localparam logic [15:0] ERR_STBY_DENIED = 16'h0001;
  localparam logic [15:0] ERR_BAD_CONTENT = 16'h0002;
  localparam logic [15:0] ERR_VOL_LOCKED = 16'h0003;
  localparam logic [15:0] ERR_GAIN_RANGE = 16'h0004;
  // audio field values
  localparam logic [7:0] GAIN_MAX = 8'h43;
  localparam logic [7:0] GAIN_RESET = 8'h31;
  localparam logic [7:0] RATE_16K = 8'h03;
  localparam logic [7:0] RATE_ANY = 8'h09;
  localparam logic [7:0] RATE_RESET = 8'h09;
  localparam logic [15:0] MUTE_OFF = 16'h0000;
  localparam logic [15:0] MUTE_ON = 16'h0001;
  // payload byte positions
  localparam logic [3:0] POS_LO = 4'h4;
  localparam logic [3:0] POS_HI = 4'h5;
  localparam logic [3:0] POS_RATE = 4'h7;
  localparam int MEM_AW = 4;
  localparam int MEM_DEPTH = 16;
  // register map
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_STATUS = 8'h04;
  localparam int CTRL_PERMIT_BIT = 0;
  localparam logic CTRL_PERMIT_RESET = 1'b1;
  localparam int STAT_MUTE_BIT = 0;
  localparam int STAT_LOCK_BIT = 1;
  localparam int STAT_STBY_BIT = 2;
  localparam int STAT_PAUSE_BIT = 3;
  localparam int STAT_STOP_BIT = 4;
  // wake time: longest allowed, rounded down to cycles
  localparam int CLK_PERIOD_NS = 10;
  localparam int WAKE_MAX_MS = 120;
  localparam int WAKE_CYCLES_DEF = WAKE_MAX_MS * 1000000 / CLK_PERIOD_NS;
  typedef enum logic [6:0] {
    ST_RX = 7'h01,
    ST_FETCH = 7'h02,
    ST_EXEC = 7'h04,
    ST_TX = 7'h08,
    ST_ARM = 7'h10,
    ST_SLEEP = 7'h20,
    ST_WAKE = 7'h40
  } pam_state_t;
endpackage

// File: test/pam_host_model.sv
// host side: sends request frames, collects device frames
`timescale 1ns/10ps
`default_nettype none
module pam_host_model (
  input wire logic clock,
  output logic rxValid,
  output logic [7:0] rxData,
  input wire logic rxReady,
  input wire logic txValid,
  input wire logic [7:0] txData,
  output logic txReady
);
  logic [7:0] got [$];
  logic slow = 1'b0;
  logic beat = 1'b0;
  initial begin
    rxValid = 1'b0;
    rxData = 8'h00;
    txReady = 1'b1;
  end
  always @(posedge clock) begin
    if (txValid && txReady) got.push_back(txData);
    beat <= !beat;
    txReady <= !slow || beat;
  end
  task automatic send(input logic [7:0] f [16], input int n);
    for (int i = 0; i < n; i++) begin
      rxValid <= 1'b1;
      rxData <= f[i];
      @(posedge clock);
      while (!rxReady) @(posedge clock);
    end
    rxValid <= 1'b0;
    rxData <= ~f[n - 1];
  endtask
endmodule // pam_host_model
`default_nettype wire

// File: test/pam_msg_handler_props.sv
// assertions for the message handler
`timescale 1ns/10ps
`default_nettype none
module pam_msg_handler_props #(
  parameter int WAKE_CYCLES = 20
) (
  input wire logic clock,
  input wire logic nrst,
  input wire logic rxReady,
  input wire logic txValid,
  input wire logic [7:0] txData,
  input wire logic txReady,
  input wire logic standbyExitPin,
  input wire logic messageReadyPin,
  input wire logic standbyReq,
  input wire logic decStopReq,
  input wire logic decStopRespSent,
  input wire logic [7:0] gainCode,
  input wire logic audioMute
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);
  logic stopPend_reg;
  logic [15:0] wakeCnt_reg;
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      stopPend_reg <= 1'b0;
    end else if (decStopReq) begin
      stopPend_reg <= 1'b1;
    end else if (decStopRespSent) begin
      stopPend_reg <= 1'b0;
    end
  end
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      wakeCnt_reg <= 16'h0000;
    end else if (messageReadyPin || standbyExitPin) begin
      wakeCnt_reg <= 16'h0000;
    end else begin
      wakeCnt_reg <= wakeCnt_reg + 16'h0001;
    end
  end
  property p_tx_len;
    $rose(txValid) |-> txData == 8'h04 || txData == 8'h06;
  endproperty
  a_tx_len: assert property (p_tx_len) else $error("bad length");
  property p_tx_hold;
    txValid && !txReady |=> txValid && $stable(txData);
  endproperty
  a_tx_hold: assert property (p_tx_hold) else $error("tx byte dropped");
  property p_rx_quiet;
    txValid |-> !rxReady;
  endproperty
  a_rx_quiet: assert property (p_rx_quiet) else $error("rx open during tx");
  property p_stby_after;
    $rose(standbyReq) |-> !txValid && !rxReady;
  endproperty
  a_stby_after: assert property (p_stby_after) else $error("early standby");
  property p_stby_excl;
    standbyReq |-> !messageReadyPin;
  endproperty
  a_stby_excl: assert property (p_stby_excl) else $error("ready in standby");
  property p_wake;
    wakeCnt_reg <= WAKE_CYCLES + 8;
  endproperty
  a_wake: assert property (p_wake) else $error("wake too slow");
  property p_exit_ind;
    $rose(messageReadyPin) |-> ##[0:8] (txValid && txData == 8'h04);
  endproperty
  a_exit_ind: assert property (p_exit_ind) else $error("no exit frame");
  property p_pause_hold;
    stopPend_reg |-> !($rose(txValid) && txData == 8'h04);
  endproperty
  a_pause_hold: assert property (p_pause_hold) else $error("pause before stop reply");
  property p_lock_mute;
    $changed(gainCode) && gainCode > pam_pkg::GAIN_MAX |-> ##[0:1] audioMute;
  endproperty
  a_lock_mute: assert property (p_lock_mute) else $error("bad gain not muted");
  c_standby: cover property ($rose(standbyReq));
  c_pause: cover property (stopPend_reg ##1 decStopRespSent);
  c_mute: cover property ($rose(audioMute));
endmodule // pam_msg_handler_props
bind pam_msg_handler pam_msg_handler_props #(.WAKE_CYCLES(WAKE_CYCLES)) u_props (.clock(clock), .nrst(nrst),
  .rxReady(rxReady), .txValid(txValid), .txData(txData), .txReady(txReady), .standbyExitPin(standbyExitPin),
  .messageReadyPin(messageReadyPin), .standbyReq(standbyReq), .decStopReq(decStopReq),
  .decStopRespSent(decStopRespSent), .gainCode(gainCode), .audioMute(audioMute));
`default_nettype wire

// File: test/test_power_and_audio_message_handler.sv
// bench for the message handler
`timescale 1ns/10ps
`default_nettype none
module test_power_and_audio_message_handler;
  logic clock, nrst, hsel, hwrite, hreadyout, rxValid, rxReady, txValid, txReady, rspSent;
  logic standbyExitPin, messageReadyPin, standbyReq, audioMute;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [4:0] ev;
  logic [7:0] rxData, txData, gainCode, sampleRate;
  logic [7:0] fr [16];
  int errors = 0;
  int tests_run = 0;
  int cycles = 0;
  pam_msg_handler #(.WAKE_CYCLES(20)) DUT (.clock, .nrst, .ce(1'b1), .hsel, .haddr, .htrans, .hwrite, .hsize,
    .hwdata, .hready(hreadyout), .hreadyout, .hresp(), .hrdata, .rxValid, .rxData, .rxReady, .txValid, .txData,
    .txReady, .standbyExitPin, .messageReadyPin, .standbyReq, .pauseCmdEvt(ev[0]), .playEndEvt(ev[1]),
    .underrunEvt(ev[2]), .decStopReq(ev[3]), .seqStopReq(ev[4]), .decStopRespSent(rspSent), .gainCode,
    .sampleRate, .audioMute);
  pam_host_model host (.clock, .rxValid, .rxData, .rxReady, .txValid, .txData, .txReady);
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  always @(posedge clock) begin
    cycles++;
    if (cycles == 20000) begin
      errors++;
      results();
    end
  end
  task results();
    $display("errors %0d of %0d checks", errors, tests_run);
    if (errors == 0 && tests_run > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task check(input logic [15:0] got, exp);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd = 32'h0000_0000);
    hsel <= 1'b1;
    htrans <= 2'b10;
    hwrite <= wr;
    haddr <= {24'h00_0000, a};
    @(posedge clock);
    while (!hreadyout) @(posedge clock);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    @(posedge clock);
    while (!hreadyout) @(posedge clock);
    rd = hrdata;
  endtask
  task req(input logic [15:0] id, len, arg, input logic [7:0] r);
    fr = '{default: 8'h00};
    {fr[1], fr[0], fr[3], fr[2]} = {len, id};
    {fr[5], fr[4]} = arg;
    fr[7] = r;
    host.send(fr, int'(len));
  endtask
  task resp(input logic [15:0] id, res, input int n);
    for (int w = 0; w < 400 && host.got.size() < n; w++) @(posedge clock);
    check({host.got[1], host.got[0]}, n == 6 ? pam_pkg::LEN_RESULT : pam_pkg::LEN_SHORT);
    check({host.got[3], host.got[2]}, id);
    if (n == 6) check({host.got[5], host.got[4]}, res);
    host.got.delete();
  endtask
  task pulse(input logic [5:0] m);
    {rspSent, ev} <= m;
    @(posedge clock);
    {rspSent, ev} <= 6'h00;
  endtask
  task cfg(input logic [7:0] g, r, input logic [15:0] res);
    req(pam_pkg::ID_CFG_REQ, pam_pkg::LEN_CONFIG, {g, 8'h00}, r);
    resp(pam_pkg::ID_CFG_RSP, res, 6);
  endtask
  task vol(input logic [15:0] off, res);
    req(pam_pkg::ID_VOL_REQ, pam_pkg::LEN_RESULT, off, 8'h00);
    resp(pam_pkg::ID_VOL_RSP, res, 6);
  endtask
  task mute(input logic [15:0] v, res);
    req(pam_pkg::ID_MUTE_REQ, pam_pkg::LEN_RESULT, v, 8'h00);
    resp(pam_pkg::ID_MUTE_RSP, res, 6);
  endtask
  task t_config();
    ahb(1'b0, pam_pkg::OFF_CTRL);
    check(rd[15:0], 16'h0001);
    ahb(1'b0, 8'h08);
    check(rd[15:0], 16'h0000);
    check({gainCode, sampleRate}, {pam_pkg::GAIN_RESET, pam_pkg::RATE_RESET});
    cfg(8'h43, pam_pkg::RATE_16K, pam_pkg::RES_OK);
    check({gainCode, sampleRate}, 16'h4303);
    cfg(8'h31, 8'h05, pam_pkg::ERR_BAD_CONTENT);
    check({gainCode, sampleRate}, 16'h4303);
    cfg(8'h44, pam_pkg::RATE_ANY, pam_pkg::ERR_GAIN_RANGE);
    check(16'(audioMute), 16'h0001);
    vol(16'h0001, pam_pkg::ERR_VOL_LOCKED);
    cfg(8'h31, pam_pkg::RATE_ANY, pam_pkg::RES_OK);
  endtask
  task t_volume();
    vol(16'hFFD0, pam_pkg::RES_OK);
    check(16'(gainCode), 16'h0001);
    vol(16'hFFFE, pam_pkg::ERR_GAIN_RANGE);
    check({gainCode, 7'h00, audioMute}, 16'h0101);
    vol(16'h0001, pam_pkg::ERR_VOL_LOCKED);
    cfg(8'h31, pam_pkg::RATE_ANY, pam_pkg::RES_OK);
    check(16'(audioMute), 16'h0000);
  endtask
  task t_mute();
    mute(pam_pkg::MUTE_ON, pam_pkg::RES_OK);
    ahb(1'b0, pam_pkg::OFF_STATUS);
    check(rd[15:0], 16'h0001);
    mute(16'h0002, pam_pkg::ERR_BAD_CONTENT);
    for (int k = 3; k < 5; k++) begin
      mute(pam_pkg::MUTE_ON, pam_pkg::RES_OK);
      pulse(6'(1 << k));
      repeat (2) @(posedge clock);
      check(16'(audioMute), 16'h0000);
    end
    pulse(6'h20);
  endtask
  task t_pause();
    host.slow = 1'b1;
    for (int k = 0; k < 3; k++) begin
      pulse(6'(1 << k));
      resp(pam_pkg::ID_PAUSE_IND, 16'h0000, 4);
    end
    pulse(6'h0A);
    repeat (12) @(posedge clock);
    check(16'(host.got.size()), 16'h0000);
    pulse(6'h20);
    resp(pam_pkg::ID_PAUSE_IND, 16'h0000, 4);
    host.slow = 1'b0;
  endtask
  task t_standby();
    ahb(1'b1, pam_pkg::OFF_CTRL, 32'h0000_0000);
    req(pam_pkg::ID_STBY_REQ, pam_pkg::LEN_SHORT, 16'h0000, 8'h00);
    resp(pam_pkg::ID_STBY_RSP, pam_pkg::ERR_STBY_DENIED, 6);
    check(16'({messageReadyPin, standbyReq}), 16'h0002);
    ahb(1'b1, pam_pkg::OFF_CTRL, 32'h0000_0001);
    req(pam_pkg::ID_STBY_REQ, pam_pkg::LEN_SHORT, 16'h0000, 8'h00);
    resp(pam_pkg::ID_STBY_RSP, pam_pkg::RES_OK, 6);
    standbyExitPin <= 1'b1;
    for (int w = 0; w < 50 && !standbyReq; w++) @(posedge clock);
    check(16'({messageReadyPin, standbyReq}), 16'h0001);
    standbyExitPin <= 1'b0;
    resp(pam_pkg::ID_STBY_EXIT, 16'h0000, 4);
    check(16'({messageReadyPin, standbyReq}), 16'h0002);
  endtask
  initial begin
    nrst = 1'b0;
    hsel = 1'b0;
    htrans = 2'b00;
    hsize = 3'b010;
    standbyExitPin = 1'b0;
    ev = 5'h00;
    rspSent = 1'b0;
    repeat (8) @(posedge clock);
    nrst <= 1'b1;
    @(posedge clock);
    t_config();
    t_volume();
    t_mute();
    t_pause();
    t_standby();
    results();
  end
endmodule // test_power_and_audio_message_handler
`default_nettype wire
